// ===== include/frg_pkg.sv
// Shared constants, types and decoders of the flash and RAM region access guard.
package frg_pkg;

	// Region geometry: 32 regions per memory.
	localparam int unsigned REGION_COUNT = 32;
	localparam int unsigned FLASH_REGION_KIB = 32;
	localparam int unsigned RAM_REGION_KIB = 8;
	localparam int unsigned FLASH_REGION_SHIFT = 15;
	localparam int unsigned RAM_REGION_SHIFT = 13;

	// Address map of the guarded spaces.
	localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
	localparam logic [31:0] FLASH_SPAN = 32'h0010_0000;
	localparam logic [31:0] RAM_BASE = 32'h2000_0000;
	localparam logic [31:0] RAM_SPAN = 32'h0004_0000;
	localparam logic [31:0] FACT_BASE = 32'h00FF_0000;
	localparam logic [31:0] UCFG_BASE = 32'h00FF_8000;
	localparam logic [31:0] CFG_SPAN = 32'h0000_1000;

	// Highest byte offset inside one region.
	localparam logic [14:0] FLASH_REGION_TOP = 15'h7FFF;
	localparam logic [14:0] RAM_REGION_TOP = 15'h1FFF;

	// Permission word layout and reset value.
	localparam int unsigned PERM_W = 5;
	localparam int unsigned PERM_READ = 0;
	localparam int unsigned PERM_WRITE = 1;
	localparam int unsigned PERM_EXEC = 2;
	localparam int unsigned PERM_SECURE = 3;
	localparam int unsigned PERM_LOCK = 4;
	localparam logic [4:0] PERM_RESET = 5'h0F;

	// Callable sub-region descriptors: two per memory, size in 32-byte steps.
	localparam int unsigned CWIN_SLOTS = 2;
	localparam int unsigned CWIN_SIZE_W = 4;
	localparam int unsigned CWIN_GRAIN_SHIFT = 5;
	localparam logic [3:0] CWIN_SIZE_RESET = 4'h0;

	// Which guarded space a transfer falls into.
	typedef enum logic [2:0] {SP_NONE, SP_FLASH, SP_RAM, SP_UCFG, SP_FACT} frg_space_t;

	// True when addr lies in [base, base + span).
	function automatic logic frg_in_range(input logic [31:0] addr, input logic [31:0] base,
		input logic [31:0] span);
		logic [31:0] off;
		off = addr - base;
		return (addr >= base) && (off < span);
	endfunction : frg_in_range

	// Region index: offset inside the space divided by the region size.
	function automatic logic [4:0] frg_region_of(input logic [31:0] addr,
		input logic [31:0] base, input int unsigned shift);
		logic [31:0] off;
		off = (addr - base) >> shift;
		return off[4:0];
	endfunction : frg_region_of

	// Merged callable size for one region: the larger matching descriptor wins.
	function automatic logic [3:0] frg_cwin_size(input logic [4:0] idx, input logic secure,
		input logic [4:0] r0, input logic [3:0] s0, input logic [4:0] r1, input logic [3:0] s1);
		logic [3:0] a;
		logic [3:0] b;
		a = (r0 == idx) ? s0 : 4'h0;
		b = (r1 == idx) ? s1 : 4'h0;
		if (!secure)
			return 4'h0;
		return (a > b) ? a : b;
	endfunction : frg_cwin_size

endpackage : frg_pkg

// ===== verilog/frg_perm_table.sv
`timescale 1ns/1ns
`default_nettype none

// One memory's permission table: 32 words with a registered read port.
module frg_perm_table
	import frg_pkg::*;
(
	// Clock and control.
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Write port.
	input wire logic wr_en,
	input wire logic [4:0] wr_idx,
	input wire logic [4:0] wr_perm,
	output logic wr_refused,
	// Read port.
	input wire logic [4:0] rd_idx,
	output logic [4:0] rd_perm
);

	logic [4:0] mem_q [REGION_COUNT];
	logic [4:0] rd_q;
	logic refused_q;
	wire locked = mem_q[wr_idx][PERM_LOCK];

	// A locked word keeps its value until reset; the attempt is flagged.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < REGION_COUNT; i++)
				mem_q[i] <= PERM_RESET;
			rd_q <= PERM_RESET;
			refused_q <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_en && !locked)
				mem_q[wr_idx] <= wr_perm;
			refused_q <= wr_en && locked;
			rd_q <= mem_q[rd_idx];
		end
	end

	assign rd_perm = rd_q;
	assign wr_refused = refused_q;

	property p_lock_refuse;
		@(posedge clk) disable iff (srst)
		(ce && wr_en && locked) |=> (mem_q[$past(wr_idx)] == $past(mem_q[wr_idx])) && wr_refused;
	endproperty
	a_lock_refuse: assert property (p_lock_refuse) else $error("Locked permissions changed.");

endmodule : frg_perm_table

`default_nettype wire

// ===== verilog/frg_access_guard.sv
`timescale 1ns/1ns
`default_nettype none

module frg_access_guard
	import frg_pkg::*;
(
	// Clock, reset and clock enable.
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Permission configuration.
	input wire logic perm_we,
	input wire logic perm_mem_ram,
	input wire logic [4:0] perm_idx,
	input wire logic [4:0] perm_value,
	output logic perm_refused,
	// Callable sub-region descriptors.
	input wire logic cwin_we,
	input wire logic cwin_mem_ram,
	input wire logic cwin_slot,
	input wire logic [4:0] cwin_region,
	input wire logic [3:0] cwin_size,
	// Transfer request from a master.
	input wire logic req_valid,
	input wire logic [31:0] req_addr,
	input wire logic req_write,
	input wire logic req_fetch,
	input wire logic req_secure,
	input wire logic req_core,
	input wire logic req_err_capable,
	input wire logic debug_active,
	// Memory side.
	output logic mem_we,
	input wire logic [31:0] mem_rdata,
	// Response toward the master.
	output logic resp_valid,
	output logic resp_blocked,
	output logic resp_in_cwin,
	output logic [31:0] resp_rdata,
	output logic bus_error,
	// Faults and events.
	output logic security_violation_exception,
	output logic bus_protection_exception,
	output logic flash_access_error_event,
	output logic ram_access_error_event,
	input wire logic access_irq_enable,
	output logic access_irq
);

	// Address decode of the incoming transfer.
	wire in_flash = frg_in_range(req_addr, FLASH_BASE, FLASH_SPAN);
	wire in_ram = frg_in_range(req_addr, RAM_BASE, RAM_SPAN);
	wire in_ucfg = frg_in_range(req_addr, UCFG_BASE, CFG_SPAN);
	wire in_fact = frg_in_range(req_addr, FACT_BASE, CFG_SPAN);
	wire [4:0] flash_rd_idx = frg_region_of(req_addr, FLASH_BASE, FLASH_REGION_SHIFT);
	wire [4:0] ram_rd_idx = frg_region_of(req_addr, RAM_BASE, RAM_REGION_SHIFT);
	frg_space_t space_d;
	assign space_d = in_flash ? SP_FLASH : in_ram ? SP_RAM : in_ucfg ? SP_UCFG :
		in_fact ? SP_FACT : SP_NONE;

	// Configuration writes steered to the addressed table.
	wire flash_we = perm_we && !perm_mem_ram;
	wire ram_we = perm_we && perm_mem_ram;
	logic flash_refused;
	logic ram_refused;
	logic [4:0] flash_perm;
	logic [4:0] ram_perm;

	// Separate tables keep each region's settings independent.
	frg_perm_table u_flash_tab (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.wr_en(flash_we),
		.wr_idx(perm_idx),
		.wr_perm(perm_value),
		.wr_refused(flash_refused),
		.rd_idx(flash_rd_idx),
		.rd_perm(flash_perm)
	);

	frg_perm_table u_ram_tab (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.wr_en(ram_we),
		.wr_idx(perm_idx),
		.wr_perm(perm_value),
		.wr_refused(ram_refused),
		.rd_idx(ram_rd_idx),
		.rd_perm(ram_perm)
	);

	assign perm_refused = flash_refused || ram_refused;

	// Callable descriptors, two per memory.
	logic [4:0] fcwin_reg_q [CWIN_SLOTS];
	logic [3:0] fcwin_size_q [CWIN_SLOTS];
	logic [4:0] rcwin_reg_q [CWIN_SLOTS];
	logic [3:0] rcwin_size_q [CWIN_SLOTS];

	// Descriptors are plain storage; validity is judged at lookup time.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < CWIN_SLOTS; i++)
			begin
				fcwin_reg_q[i] <= 5'h00;
				fcwin_size_q[i] <= CWIN_SIZE_RESET;
				rcwin_reg_q[i] <= 5'h00;
				rcwin_size_q[i] <= CWIN_SIZE_RESET;
			end
		end
		else if (ce && cwin_we)
		begin
			if (cwin_mem_ram)
			begin
				rcwin_reg_q[cwin_slot] <= cwin_region;
				rcwin_size_q[cwin_slot] <= cwin_size;
			end
			else
			begin
				fcwin_reg_q[cwin_slot] <= cwin_region;
				fcwin_size_q[cwin_slot] <= cwin_size;
			end
		end
	end

	// Transfer attributes held while the table lookup completes.
	logic s1_valid_q;
	logic [31:0] s1_addr_q;
	logic s1_write_q;
	logic s1_fetch_q;
	logic s1_secure_q;
	logic s1_core_q;
	logic s1_errcap_q;
	logic s1_debug_q;
	frg_space_t s1_space_q;

	// The lookup stage is one register deep, matching the table read.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s1_valid_q <= 1'b0;
			s1_addr_q <= 32'h0000_0000;
			s1_write_q <= 1'b0;
			s1_fetch_q <= 1'b0;
			s1_secure_q <= 1'b0;
			s1_core_q <= 1'b0;
			s1_errcap_q <= 1'b0;
			s1_debug_q <= 1'b0;
			s1_space_q <= SP_NONE;
		end
		else if (ce)
		begin
			s1_valid_q <= req_valid;
			s1_addr_q <= req_addr;
			s1_write_q <= req_write;
			s1_fetch_q <= req_fetch && !req_write;
			s1_secure_q <= req_secure;
			s1_core_q <= req_core;
			s1_errcap_q <= req_err_capable;
			s1_debug_q <= debug_active;
			s1_space_q <= space_d;
		end
	end

	// Region attributes of the transfer under check.
	wire s1_is_flash = (s1_space_q == SP_FLASH);
	wire s1_is_ram = (s1_space_q == SP_RAM);
	wire s1_is_cfg = (s1_space_q == SP_UCFG) || (s1_space_q == SP_FACT);
	wire [4:0] s1_perm = s1_is_flash ? flash_perm : ram_perm;
	wire [4:0] s1_fidx = frg_region_of(s1_addr_q, FLASH_BASE, FLASH_REGION_SHIFT);
	wire [4:0] s1_ridx = frg_region_of(s1_addr_q, RAM_BASE, RAM_REGION_SHIFT);
	wire s1_reg_secure = s1_perm[PERM_SECURE];

	// Callable size: zero unless the region is secure and a descriptor names it.
	wire [3:0] fcwin_len = frg_cwin_size(s1_fidx, flash_perm[PERM_SECURE], fcwin_reg_q[0],
		fcwin_size_q[0], fcwin_reg_q[1], fcwin_size_q[1]);
	wire [3:0] rcwin_len = frg_cwin_size(s1_ridx, ram_perm[PERM_SECURE], rcwin_reg_q[0],
		rcwin_size_q[0], rcwin_reg_q[1], rcwin_size_q[1]);
	wire [3:0] cwin_len = s1_is_flash ? fcwin_len : rcwin_len;
	wire [14:0] cwin_bytes = {6'h00, cwin_len, 5'h00};

	// Distance from the region top decides membership of the callable window.
	wire [14:0] reg_top = s1_is_flash ? FLASH_REGION_TOP : RAM_REGION_TOP;
	wire [14:0] reg_off = s1_is_flash ? s1_addr_q[14:0] : {2'b00, s1_addr_q[12:0]};
	wire [14:0] top_dist = reg_top - reg_off;
	wire s1_in_cwin = (s1_is_flash || s1_is_ram) && (cwin_len != 4'h0) &&
		(top_dist < cwin_bytes);

	// A non-secure call may only enter through the callable window by fetching.
	wire cwin_entry = s1_in_cwin && s1_fetch_q;
	wire mem_sec_viol = s1_reg_secure && !s1_secure_q && !cwin_entry;
	wire cfg_sec_viol = !s1_secure_q;

	// Debug stepping relaxes execute checks in flash and in the configuration areas, not in RAM.
	wire exec_ok = s1_perm[PERM_EXEC] || (s1_debug_q && s1_is_flash);
	wire mem_perm_viol = s1_fetch_q ? !exec_ok :
		s1_write_q ? !s1_perm[PERM_WRITE] : !s1_perm[PERM_READ];
	wire cfg_fetch_viol = s1_fetch_q && !s1_debug_q;
	wire fact_write_viol = (s1_space_q == SP_FACT) && s1_write_q;
	wire cfg_perm_viol = cfg_fetch_viol || fact_write_viol;

	// Combined verdict; unguarded addresses pass untouched.
	wire sec_viol = s1_valid_q && (((s1_is_flash || s1_is_ram) && mem_sec_viol) ||
		(s1_is_cfg && cfg_sec_viol));
	wire perm_viol = s1_valid_q && (((s1_is_flash || s1_is_ram) && mem_perm_viol) ||
		(s1_is_cfg && cfg_perm_viol));
	wire viol = sec_viol || perm_viol;

	// Fault and event routing by master type.
	wire core_sec = s1_core_q && sec_viol;
	wire core_bus = s1_core_q && perm_viol && !sec_viol;
	wire evt_any = viol && !core_sec;
	wire flash_evt_d = evt_any && !s1_is_ram;
	wire ram_evt_d = evt_any && s1_is_ram;

	// The write strobe is gated here so a blocked write never reaches memory.
	assign mem_we = ce && s1_valid_q && s1_write_q && !viol;

	logic resp_valid_q;
	logic resp_blocked_q;
	logic resp_in_cwin_q;
	logic [31:0] rdata_q;
	logic bus_err_q;
	logic sec_exc_q;
	logic bus_exc_q;
	logic flash_evt_q;
	logic ram_evt_q;
	logic irq_q;

	// Response registers; blocked reads never carry memory contents.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			resp_valid_q <= 1'b0;
			resp_blocked_q <= 1'b0;
			resp_in_cwin_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			bus_err_q <= 1'b0;
			sec_exc_q <= 1'b0;
			bus_exc_q <= 1'b0;
			flash_evt_q <= 1'b0;
			ram_evt_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else if (ce)
		begin
			resp_valid_q <= s1_valid_q;
			resp_blocked_q <= viol;
			resp_in_cwin_q <= s1_valid_q && s1_in_cwin;
			rdata_q <= (viol || s1_write_q || !s1_valid_q) ? 32'h0000_0000 : mem_rdata;
			bus_err_q <= viol && s1_errcap_q;
			sec_exc_q <= core_sec;
			bus_exc_q <= core_bus;
			flash_evt_q <= flash_evt_d;
			ram_evt_q <= ram_evt_d;
			irq_q <= (flash_evt_d || ram_evt_d) && access_irq_enable;
		end
	end

	assign resp_valid = resp_valid_q;
	assign resp_blocked = resp_blocked_q;
	assign resp_in_cwin = resp_in_cwin_q;
	assign resp_rdata = rdata_q;
	assign bus_error = bus_err_q;
	assign security_violation_exception = sec_exc_q;
	assign bus_protection_exception = bus_exc_q;
	assign flash_access_error_event = flash_evt_q;
	assign ram_access_error_event = ram_evt_q;
	assign access_irq = irq_q;

	property p_read_zero;
		@(posedge clk) disable iff (srst)
		resp_valid && resp_blocked |-> resp_rdata == 32'h0000_0000;
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("Blocked read leaked data.");

	property p_block_write;
		@(posedge clk) disable iff (srst)
		ce && viol |-> !mem_we ##1 resp_blocked;
	endproperty
	a_block_write: assert property (p_block_write) else $error("Blocked write passed.");

	property p_sec_no_event;
		@(posedge clk) disable iff (srst)
		security_violation_exception |-> !flash_access_error_event && !ram_access_error_event;
	endproperty
	a_sec_no_event: assert property (p_sec_no_event) else $error("Event on core security fault.");

	property p_bus_event;
		@(posedge clk) disable iff (srst)
		bus_protection_exception |-> flash_access_error_event || ram_access_error_event;
	endproperty
	a_bus_event: assert property (p_bus_event) else $error("Bus fault without event.");

	property p_precedence;
		@(posedge clk) disable iff (srst)
		ce && core_sec |=> security_violation_exception && !bus_protection_exception;
	endproperty
	a_precedence: assert property (p_precedence) else $error("Bus fault beat security fault.");

	property p_noncore;
		@(posedge clk) disable iff (srst)
		ce && viol && !s1_core_q |=> resp_blocked && !security_violation_exception &&
			!bus_protection_exception && (flash_access_error_event != ram_access_error_event);
	endproperty
	a_noncore: assert property (p_noncore) else $error("Non-core violation misreported.");

	property p_cfg_fetch;
		@(posedge clk) disable iff (srst)
		ce && s1_valid_q && s1_is_cfg && s1_fetch_q && !s1_debug_q |=> resp_blocked;
	endproperty
	a_cfg_fetch: assert property (p_cfg_fetch) else $error("Config area fetch allowed.");

	property p_irq;
		@(posedge clk) disable iff (srst)
		access_irq |-> (flash_access_error_event || ram_access_error_event) && $past(access_irq_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt without enabled event.");

	property p_nonsecure_cwin;
		@(posedge clk) disable iff (srst)
		ce && s1_valid_q && s1_is_flash && !flash_perm[PERM_SECURE] |=> !resp_in_cwin;
	endproperty
	a_nonsecure_cwin: assert property (p_nonsecure_cwin) else $error("Callable in open region.");

endmodule : frg_access_guard

`default_nettype wire

// ===== tb/frg_mem_model.sv
`timescale 1ns/1ns
`default_nettype none

// Memory behind the guard. It answers every read with one fixed word and counts writes.
// The word is nonzero, so a zero on a read response can only come from the guard blocking.
module frg_mem_model
	import frg_pkg::*;
#(
	parameter logic [31:0] READ_WORD = 32'h5A5A_C3C3
)
(
	// Clock.
	input wire logic clk,
	// Memory port.
	input wire logic mem_we,
	output logic [31:0] mem_rdata,
	// Write bookkeeping.
	output int unsigned wr_count
);
	// Read data does not depend on the address.
	assign mem_rdata = READ_WORD;

	// Every write that reaches the memory is counted at the clock edge.
	int unsigned cnt_q = 0;
	assign wr_count = cnt_q;
	always @(posedge clk)
	begin
		if (mem_we === 1'b1)
			cnt_q <= cnt_q + 1;
	end
endmodule : frg_mem_model

`default_nettype wire

// ===== tb/frg_access_guard_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

// Bench for the region access guard. Inputs change at the falling edge only.
module frg_access_guard_tb_top
	import frg_pkg::*;
();
	localparam logic [31:0] MEM_WORD = 32'h5A5A_C3C3;

	// Stimulus and observation signals.
	logic clk = 1'b0, srst = 1'b1, ce = 1'b1;
	logic perm_we = 1'b0, perm_mem_ram = 1'b0;
	logic cwin_we = 1'b0, cwin_mem_ram = 1'b0, cwin_slot = 1'b0;
	logic [4:0] perm_idx = 5'h0, perm_value = 5'h0, cwin_region = 5'h0;
	logic [3:0] cwin_size = 4'h0;
	logic req_valid = 1'b0, req_write = 1'b0, req_fetch = 1'b0, req_secure = 1'b0;
	logic req_core = 1'b0, req_err_capable = 1'b0, debug_active = 1'b0, access_irq_enable = 1'b0;
	logic [31:0] req_addr = 32'h0;
	wire logic [31:0] mem_rdata, resp_rdata;
	wire logic perm_refused, mem_we, resp_valid, resp_blocked, resp_in_cwin, bus_error;
	wire logic security_violation_exception, bus_protection_exception;
	wire logic flash_access_error_event, ram_access_error_event, access_irq;
	int unsigned wr_count;
	int n_fail = 0;
	int n_tests = 0;

	// Clock of 100 ns period.
	always #50 clk = ~clk;

	// Device under test and the memory it guards.
	frg_access_guard i_frg_access_guard (.clk, .srst, .ce, .perm_we, .perm_mem_ram, .perm_idx,
		.perm_value, .perm_refused, .cwin_we, .cwin_mem_ram, .cwin_slot, .cwin_region,
		.cwin_size,
		.req_valid, .req_addr, .req_write, .req_fetch, .req_secure, .req_core, .req_err_capable,
		.debug_active, .mem_we, .mem_rdata, .resp_valid, .resp_blocked, .resp_in_cwin,
		.resp_rdata, .bus_error, .security_violation_exception, .bus_protection_exception,
		.flash_access_error_event, .ram_access_error_event, .access_irq_enable, .access_irq);
	frg_mem_model #(.READ_WORD(MEM_WORD)) i_frg_mem_model (.clk, .mem_we, .mem_rdata, .wr_count);

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic end_of_test();
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// One permission write; the refusal flag is looked at in the following cycle.
	task automatic set_perm(input logic ram, input logic [4:0] idx, input logic [4:0] val,
		input logic refused);
		@(negedge clk);
		perm_we = 1'b1;
		perm_mem_ram = ram;
		perm_idx = idx;
		perm_value = val;
		@(negedge clk);
		perm_we = 1'b0;
		chk("perm_refused", {31'h0, perm_refused}, {31'h0, refused});
	endtask : set_perm

	task automatic set_cwin(input logic ram, input logic slot, input logic [4:0] r,
		input logic [3:0] s);
		@(negedge clk);
		cwin_we = 1'b1;
		cwin_mem_ram = ram;
		cwin_slot = slot;
		cwin_region = r;
		cwin_size = s;
		@(negedge clk);
		cwin_we = 1'b0;
	endtask : set_cwin

	// One transfer. f = {irq enable, debug, error capable, core, secure, fetch, write}.
	// k: 0 allowed, 1 permission, 2 security, 3 both. The response stands one cycle only,
	// between the second and third edges after the request, so it is read in that cycle.
	task automatic xfer(input logic [31:0] a, input logic [6:0] f, input logic [1:0] k,
		input logic cw);
		logic blk;
		logic ev;
		logic [8:0] exp;
		int unsigned w0;
		blk = (k != 2'h0);
		ev = blk && !(f[3] && k[1]);
		exp = {1'b1, blk, cw, blk && f[4], f[3] && k[1], f[3] && (k == 2'h1),
			ev && (a < RAM_BASE), ev && (a >= RAM_BASE), ev && f[6]};
		w0 = wr_count;
		@(negedge clk);
		req_valid = 1'b1;
		req_addr = a;
		{access_irq_enable, debug_active, req_err_capable, req_core, req_secure, req_fetch,
			req_write} = f;
		@(negedge clk);
		req_valid = 1'b0;
		@(negedge clk);
		chk("flags", {23'h0, resp_valid, resp_blocked, resp_in_cwin, bus_error,
			security_violation_exception, bus_protection_exception, flash_access_error_event,
			ram_access_error_event, access_irq}, {23'h0, exp});
		chk("rdata", resp_rdata, (blk || f[0]) ? 32'h0 : MEM_WORD);
		chk("writes", 32'(wr_count - w0), {31'h0, f[0] && !blk});
	endtask : xfer

	// Reset permissions make every region secure with full access.
	task automatic t_reset_state();
		xfer(FLASH_BASE, 7'h1C, 2'h0, 1'b0);
		xfer(32'h0000_0004, 7'h18, 2'h2, 1'b0);
		xfer(RAM_BASE, 7'h1D, 2'h0, 1'b0);
	endtask : t_reset_state

	// Flash region 5 made execute only, then write only; edges of the region probed.
	task automatic t_flash_bits();
		set_perm(1'b0, 5'h05, 5'h04, 1'b0);
		xfer(32'h0002_8000, 7'h18, 2'h1, 1'b0);
		xfer(32'h0002_FFFC, 7'h1A, 2'h0, 1'b0);
		xfer(32'h0002_8010, 7'h19, 2'h1, 1'b0);
		xfer(32'h0003_0000, 7'h1A, 2'h2, 1'b0);
		set_perm(1'b0, 5'h05, 5'h02, 1'b0);
		xfer(32'h0002_8000, 7'h19, 2'h0, 1'b0);
		xfer(32'h0002_8000, 7'h50, 2'h1, 1'b0);
		xfer(32'h0002_8000, 7'h10, 2'h1, 1'b0);
		set_perm(1'b0, 5'h0B, 5'h09, 1'b0);
		xfer(32'h0005_8000, 7'h19, 2'h3, 1'b0);
		xfer(32'h0005_8000, 7'h1D, 2'h1, 1'b0);
	endtask : t_flash_bits

	// RAM regions of 8 KiB: region 31 opened, its neighbour left secure.
	task automatic t_ram();
		set_perm(1'b1, 5'h1F, 5'h03, 1'b0);
		xfer(32'h2003_E000, 7'h19, 2'h0, 1'b0);
		xfer(32'h2003_FFFC, 7'h52, 2'h1, 1'b0);
		xfer(32'h2003_DFFC, 7'h50, 2'h2, 1'b0);
		xfer(32'h2003_DFFC, 7'h00, 2'h2, 1'b0);
	endtask : t_ram

	// A locked region refuses changes; the other table's same index stays free.
	task automatic t_lock_debug();
		set_perm(1'b0, 5'h07, 5'h13, 1'b0);
		set_perm(1'b0, 5'h07, 5'h0F, 1'b1);
		xfer(32'h0003_8000, 7'h18, 2'h0, 1'b0);
		xfer(32'h0003_8000, 7'h1A, 2'h1, 1'b0);
		xfer(32'h0003_8000, 7'h3A, 2'h0, 1'b0);
		set_perm(1'b1, 5'h07, 5'h00, 1'b0);
		xfer(32'h2000_E000, 7'h1C, 2'h1, 1'b0);
	endtask : t_lock_debug

	// Configuration areas: always secure, factory area read only, fetches need debug.
	task automatic t_cfg();
		xfer(UCFG_BASE, 7'h1C, 2'h0, 1'b0);
		xfer(UCFG_BASE, 7'h1D, 2'h0, 1'b0);
		xfer(UCFG_BASE + 32'h4, 7'h18, 2'h2, 1'b0);
		xfer(FACT_BASE, 7'h1D, 2'h1, 1'b0);
		xfer(FACT_BASE, 7'h1E, 2'h1, 1'b0);
		xfer(UCFG_BASE, 7'h3E, 2'h0, 1'b0);
		xfer(UCFG_BASE, 7'h1A, 2'h3, 1'b0);
	endtask : t_cfg

	// Callable windows at region tops; merged sizes, zero size and non-secure targets.
	task automatic t_cwin();
		set_cwin(1'b0, 1'b0, 5'h09, 4'h2);
		set_cwin(1'b0, 1'b1, 5'h09, 4'h4);
		xfer(32'h0004_FF80, 7'h1A, 2'h0, 1'b1);
		xfer(32'h0004_FF7C, 7'h1A, 2'h2, 1'b0);
		set_cwin(1'b0, 1'b0, 5'h05, 4'h4);
		xfer(32'h0002_FFF0, 7'h19, 2'h0, 1'b0);
		set_cwin(1'b0, 1'b1, 5'h09, 4'h0);
		xfer(32'h0004_FFF0, 7'h1A, 2'h2, 1'b0);
		set_cwin(1'b1, 1'b0, 5'h03, 4'h1);
		xfer(32'h2000_7FE0, 7'h1A, 2'h0, 1'b1);
		xfer(32'h2000_7FDC, 7'h1A, 2'h2, 1'b0);
	endtask : t_cwin

	// With the clock enable low a permission write must leave no trace on region 12.
	task automatic t_freeze();
		ce = 1'b0;
		set_perm(1'b0, 5'h0C, 5'h00, 1'b0);
		ce = 1'b1;
		xfer(32'h0006_0000, 7'h1C, 2'h0, 1'b0);
	endtask : t_freeze

	// Main sequence: 16 cycles of reset, then the scenarios in turn.
	initial
	begin
		repeat (16) @(negedge clk);
		srst = 1'b0;
		t_reset_state();
		t_freeze();
		t_flash_bits();
		t_ram();
		t_lock_debug();
		t_cfg();
		t_cwin();
		end_of_test();
	end

	// Watchdog with ample margin over the 144 cycles the reset and the scenarios need.
	initial
	begin
		repeat (3000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
endmodule : frg_access_guard_tb_top

`default_nettype wire
